// [design/cic_edge_det.sv]
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser plus selectable edge detector for the pin
module cic_edge_det (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic pin_in,
  input wire logic rise_sel,
  output logic edge_hit
);
  logic sync1; // first stage, read by sync2 only
  logic sync2;
  logic last; // previous synchronised level

  // synchroniser and history
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      last <= sync2;
    end
  end

  // rising when selected, else falling
  always_comb
  begin
    edge_hit = rise_sel ? (sync2 & ~last) : (~sync2 & last);
  end
endmodule
`default_nettype wire

// [design/cic_top.sv]
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - reset clears global and individual enables
// - vector needs global and own enables; peripheral sources also need group enable
// - flags set regardless of enables
// - entry flushes, clears gie, pushes, saves, vectors
// - gie clear holds requests until re-enabled
// - return pops, restores context, sets gie
// - synchronous latency three or four cycles
// - asynchronous latency three to five cycles
// - latency independent of instruction length
// - pin flag sampled at every Q1
// - enabled source wakes core from sleep
// - instruction after sleep runs before vector
// - pin edge select rising or falling
// - pin edge sets flag; vector needs enables
// - entry shadows context; return restores it
// - shadows readable and writable by software
// - control register bit layout, resets zero
// - timer0 overflow sets bit 2 flag
// - change flag read-only, or of per-pin flags
// - sleep wake pushes pc plus one
module cic_top #(
  parameter int PC_W = 15
) (
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // event sources
  input wire logic ext_irq_pin,
  input wire logic timer0_overflow,
  input wire logic [7:0] per_pin_change_flags,
  input wire logic [7:0] periph_set_1,
  input wire logic [7:0] periph_set_2,
  // cpu side
  input wire logic [1:0] q_phase,
  input wire logic cpu_sleeping,
  input wire logic [PC_W-1:0] cpu_pc,
  input wire logic ret_from_irq,
  input wire logic [7:0] cur_w,
  input wire logic [7:0] cur_status,
  input wire logic [7:0] cur_bank_select,
  input wire logic [7:0] cur_file_select,
  input wire logic [7:0] cur_pc_high_latch,
  output logic flush_prefetch,
  output logic push_pc,
  output logic [PC_W-1:0] push_addr,
  output logic load_vector,
  output logic [PC_W-1:0] vector_addr,
  output logic wake_core,
  output logic restore_ctx,
  output logic [7:0] rst_w,
  output logic [7:0] rst_status,
  output logic [7:0] rst_bank_select,
  output logic [7:0] rst_file_select,
  output logic [7:0] rst_pc_high_latch
);
  // elaboration check: the vector must fit the pc
  if (PC_W < 15)
  begin : g_bad_pc_w
    $error("PC_W too narrow for the vector");
  end

  logic [7:0] intctl; // interrupt_control, low bit computed
  logic [7:0] pflag1;
  logic [7:0] pflag2;
  logic [7:0] pen1;
  logic [7:0] pen2;
  logic edge_rise; // ext_edge_select
  logic [7:0] sh_w;
  logic [7:0] sh_stat;
  logic [7:0] sh_bsr;
  logic [7:0] sh_fsr;
  logic [7:0] sh_pcl;
  cic_pkg::cic_state_t state;
  logic ext_edge; // valid pin edge
  logic t0_sync1;
  logic t0_sync2;
  logic t0_last;
  logic pend_q1; // pending sampled at q1
  logic wake_arm; // woke, one instruction owed
  logic pending;
  logic ctl_wr;

  cic_edge_det u_edge (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in(ext_irq_pin),
    .rise_sel(edge_rise),
    .edge_hit(ext_edge)
  );

  // timer0 overflow comes from logic on this clock but kept as event edge
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      t0_sync1 <= 1'b0;
      t0_sync2 <= 1'b0;
      t0_last <= 1'b0;
    end
    else
    begin
      t0_sync1 <= timer0_overflow;
      t0_sync2 <= t0_sync1;
      t0_last <= t0_sync2;
    end
  end

  function automatic logic any_req(input logic [7:0] c, input logic [7:0] f1,
                                   input logic [7:0] f2, input logic [7:0] e1,
                                   input logic [7:0] e2);
    any_req = (c[cic_pkg::B_T0IE] & c[cic_pkg::B_T0IF])
            | (c[cic_pkg::B_EXIE] & c[cic_pkg::B_EXIF])
            | (c[cic_pkg::B_PCIE] & c[cic_pkg::B_PCIF])
            | (c[cic_pkg::B_PERIPHERAL_GROUP_ENABLE] & (|(f1 & e1) | |(f2 & e2)));
  endfunction

  // enabled request, without the global gate (wake needs no gie)
  always_comb
  begin
    pending = any_req(intctl, pflag1, pflag2, pen1, pen2);
    ctl_wr = reg_wr && (reg_addr == cic_pkg::REG_INTCTL);
  end

  // control register, flags win over software clears
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      intctl <= cic_pkg::INTCTL_RST;
    else
    begin
      if (ctl_wr)
        intctl[7:1] <= reg_wdata[7:1];
      if (state == cic_pkg::CIC_FLUSH)
        intctl[cic_pkg::B_GIE] <= 1'b0;
      else if (ret_from_irq)
        intctl[cic_pkg::B_GIE] <= 1'b1;
      if (t0_sync2 && !t0_last)
        intctl[cic_pkg::B_T0IF] <= 1'b1;
      if (ext_edge)
        intctl[cic_pkg::B_EXIF] <= 1'b1;
      // read-only: follows per-pin flags, no software write
      intctl[cic_pkg::B_PCIF] <= |per_pin_change_flags;
    end
  end

  // peripheral flag and enable registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pflag1 <= 8'h00;
      pflag2 <= 8'h00;
      pen1 <= 8'h00;
      pen2 <= 8'h00;
      edge_rise <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == cic_pkg::REG_PEN1)
        pen1 <= reg_wdata;
      if (reg_wr && reg_addr == cic_pkg::REG_PEN2)
        pen2 <= reg_wdata;
      if (reg_wr && reg_addr == cic_pkg::REG_OPTS)
        edge_rise <= reg_wdata[0];
      // set beats clear in the same cycle
      pflag1 <= ((reg_wr && reg_addr == cic_pkg::REG_PFLAG1) ? reg_wdata : pflag1)
              | periph_set_1;
      pflag2 <= ((reg_wr && reg_addr == cic_pkg::REG_PFLAG2) ? reg_wdata : pflag2)
              | periph_set_2;
    end
  end

  // q1 sampling of the combined request
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pend_q1 <= 1'b0;
    else if (q_phase == cic_pkg::Q1)
      pend_q1 <= pending & intctl[cic_pkg::B_GIE];
  end

  // wake: one instruction must run after sleep before the vector
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wake_core <= 1'b0;
      wake_arm <= 1'b0;
    end
    else
    begin
      wake_core <= cpu_sleeping & pending;
      if (cpu_sleeping && pending)
        wake_arm <= 1'b1;
      else if (!cpu_sleeping && q_phase == cic_pkg::Q4)
        wake_arm <= 1'b0;
    end
  end

  // entry sequencer; decision at q4 fixes latency regardless of length
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      state <= cic_pkg::CIC_RUN;
    else
      unique case (state)
        cic_pkg::CIC_RUN:
          if (pend_q1 && !wake_arm && !cpu_sleeping && q_phase == cic_pkg::Q4
              && intctl[cic_pkg::B_GIE])
            state <= cic_pkg::CIC_FLUSH;
        cic_pkg::CIC_FLUSH:
          state <= cic_pkg::CIC_VECT;
        cic_pkg::CIC_VECT:
          state <= cic_pkg::CIC_RUN;
      endcase
  end

  // cpu strobes, one cycle each except restore_ctx, which lasts as long as ret_from_irq
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flush_prefetch <= 1'b0;
      push_pc <= 1'b0;
      push_addr <= '0;
      load_vector <= 1'b0;
      vector_addr <= '0;
      restore_ctx <= 1'b0;
    end
    else
    begin
      flush_prefetch <= (state == cic_pkg::CIC_RUN) && pend_q1 && !wake_arm
                        && !cpu_sleeping && q_phase == cic_pkg::Q4
                        && intctl[cic_pkg::B_GIE];
      push_pc <= (state == cic_pkg::CIC_FLUSH);
      // cpu_pc already points past the post-sleep instruction
      push_addr <= cpu_pc;
      load_vector <= (state == cic_pkg::CIC_VECT);
      vector_addr <= PC_W'(cic_pkg::VECTOR_ADDR);
      restore_ctx <= ret_from_irq;
    end
  end

  // shadow registers: captured on entry, software may overwrite
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sh_w <= 8'h00;
      sh_stat <= 8'h00;
      sh_bsr <= 8'h00;
      sh_fsr <= 8'h00;
      sh_pcl <= 8'h00;
    end
    else if (state == cic_pkg::CIC_FLUSH)
    begin
      sh_w <= cur_w;
      sh_stat <= cur_status & ~cic_pkg::STAT_KEEP_MASK;
      sh_bsr <= cur_bank_select;
      sh_fsr <= cur_file_select;
      sh_pcl <= cur_pc_high_latch;
    end
    else if (reg_wr)
    begin
      if (reg_addr == cic_pkg::REG_SH_W)
        sh_w <= reg_wdata;
      if (reg_addr == cic_pkg::REG_SH_STAT)
        sh_stat <= reg_wdata & ~cic_pkg::STAT_KEEP_MASK;
      if (reg_addr == cic_pkg::REG_SH_BSR)
        sh_bsr <= reg_wdata;
      if (reg_addr == cic_pkg::REG_SH_FSR)
        sh_fsr <= reg_wdata;
      if (reg_addr == cic_pkg::REG_SH_PCL)
        sh_pcl <= reg_wdata;
    end
  end

  // restore values; timeout and powerdown pass through live
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_w <= 8'h00;
      rst_status <= 8'h00;
      rst_bank_select <= 8'h00;
      rst_file_select <= 8'h00;
      rst_pc_high_latch <= 8'h00;
    end
    else
    begin
      rst_w <= sh_w;
      rst_status <= sh_stat | (cur_status & cic_pkg::STAT_KEEP_MASK);
      rst_bank_select <= sh_bsr;
      rst_file_select <= sh_fsr;
      rst_pc_high_latch <= sh_pcl;
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      unique case (reg_addr)
        cic_pkg::REG_INTCTL: reg_rdata <= intctl;
        cic_pkg::REG_PFLAG1: reg_rdata <= pflag1;
        cic_pkg::REG_PFLAG2: reg_rdata <= pflag2;
        cic_pkg::REG_PEN1: reg_rdata <= pen1;
        cic_pkg::REG_PEN2: reg_rdata <= pen2;
        cic_pkg::REG_OPTS: reg_rdata <= {7'h00, edge_rise};
        cic_pkg::REG_SH_W: reg_rdata <= sh_w;
        cic_pkg::REG_SH_STAT: reg_rdata <= sh_stat;
        cic_pkg::REG_SH_BSR: reg_rdata <= sh_bsr;
        cic_pkg::REG_SH_FSR: reg_rdata <= sh_fsr;
        cic_pkg::REG_SH_PCL: reg_rdata <= sh_pcl;
        cic_pkg::REG_STATE: reg_rdata <= {5'h00, wake_arm, state};
        default: reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end

  property p_reset_clear;
    @(posedge ref_clk) $rose(rstn) |-> !intctl[cic_pkg::B_GIE] && pen1 == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enables not clear");

  property p_gie_drop;
    @(posedge ref_clk) disable iff (!rstn)
      flush_prefetch |=> !intctl[cic_pkg::B_GIE] ##1 load_vector;
  endproperty
  a_gie_drop: assert property (p_gie_drop) else $error("entry order wrong");

  property p_no_entry_gie_off;
    @(posedge ref_clk) disable iff (!rstn)
      !intctl[cic_pkg::B_GIE] && state == cic_pkg::CIC_RUN |=> !flush_prefetch;
  endproperty
  a_no_entry_gie_off: assert property (p_no_entry_gie_off) else $error("entry without gie");

  property p_ret_gie;
    @(posedge ref_clk) disable iff (!rstn)
      ret_from_irq && state == cic_pkg::CIC_RUN |=> intctl[cic_pkg::B_GIE] && restore_ctx;
  endproperty
  a_ret_gie: assert property (p_ret_gie) else $error("return did not set gie");

  property p_ext_flag;
    @(posedge ref_clk) disable iff (!rstn) ext_edge |=> intctl[cic_pkg::B_EXIF];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("pin flag not set");

  property p_pcif;
    @(posedge ref_clk) disable iff (!rstn)
      (|per_pin_change_flags) |=> intctl[cic_pkg::B_PCIF];
  endproperty
  a_pcif: assert property (p_pcif) else $error("change flag wrong");

  property p_vec_addr;
    @(posedge ref_clk) disable iff (!rstn)
      load_vector |-> vector_addr == PC_W'(cic_pkg::VECTOR_ADDR);
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("bad vector");

  property p_shadow_save;
    @(posedge ref_clk) disable iff (!rstn)
      state == cic_pkg::CIC_FLUSH |=> sh_w == $past(cur_w);
  endproperty
  a_shadow_save: assert property (p_shadow_save) else $error("shadow not saved");

  c_entry: cover property (@(posedge ref_clk) disable iff (!rstn) load_vector);
  c_wake: cover property (@(posedge ref_clk) disable iff (!rstn) wake_core);
  c_ret: cover property (@(posedge ref_clk) disable iff (!rstn) restore_ctx);
endmodule
`default_nettype wire

// [shared/cic_pkg.sv]
`default_nettype none
package cic_pkg;
  // register map of this block (word index = byte address here, plain port)
  localparam logic [3:0] REG_INTCTL = 4'h0; // interrupt_control
  localparam logic [3:0] REG_PFLAG1 = 4'h1; // periph_request_flags_1
  localparam logic [3:0] REG_PFLAG2 = 4'h2; // periph_request_flags_2
  localparam logic [3:0] REG_PEN1 = 4'h3; // periph_enable_regs, first
  localparam logic [3:0] REG_PEN2 = 4'h4; // periph_enable_regs, second
  localparam logic [3:0] REG_OPTS = 4'h5; // ext_edge_select at bit 0
  localparam logic [3:0] REG_SH_W = 4'h6; // shadow working register
  localparam logic [3:0] REG_SH_STAT = 4'h7; // shadow status
  localparam logic [3:0] REG_SH_BSR = 4'h8; // shadow bank_select
  localparam logic [3:0] REG_SH_FSR = 4'h9; // shadow file_select
  localparam logic [3:0] REG_SH_PCL = 4'hA; // shadow pc_high_latch
  localparam logic [3:0] REG_STATE = 4'hB; // read-only engine state
  // interrupt_control field positions
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_GROUP_ENABLE = 6;
  localparam int B_T0IE = 5;
  localparam int B_EXIE = 4;
  localparam int B_PCIE = 3;
  localparam int B_T0IF = 2;
  localparam int B_EXIF = 1;
  localparam int B_PCIF = 0;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  // status bits kept live through a return: timeout and powerdown
  localparam logic [7:0] STAT_KEEP_MASK = 8'h18;
  localparam logic [14:0] VECTOR_ADDR = 15'h0004;
  // q phase count per instruction cycle
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q4 = 2'h3;
  // reference clock at 50 MHz, one q phase per clock, four q phases per instruction
  localparam int CLK_NS = 20;
  // entry sequencer states, gray coded except the CIC_VECT to CIC_RUN step
  typedef enum logic [1:0] {
    CIC_RUN = 2'b00,
    CIC_FLUSH = 2'b01,
    CIC_VECT = 2'b11
  } cic_state_t;
endpackage
`default_nettype wire

// [testbench/cic_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// core sequencer stand-in: free q phases and a stepping pc
module cic_core_model #(
  parameter int PC_W = 15
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic load_vector,
  input wire logic [PC_W-1:0] vector_addr,
  output logic [1:0] q_phase,
  output logic [PC_W-1:0] cpu_pc
);
  // one instruction per four phases; vector load redirects the pc
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q_phase <= cic_pkg::Q1;
      cpu_pc <= '0;
    end
    else
    begin
      q_phase <= q_phase + 2'h1;
      // redirect wins over the normal step
      if (load_vector)
        cpu_pc <= vector_addr;
      else if (q_phase == cic_pkg::Q4)
        cpu_pc <= cpu_pc + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [testbench/cpu_interrupt_controller_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_controller_bench;
  logic ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, v = 8'h00, nw, s0;
  logic ext_irq_pin = 1'b1, t0_ovf = 1'b0, cpu_sleeping = 1'b0, ret_from_irq = 1'b0;
  logic [7:0] chg = 8'h00, ps1 = 8'h00, ps2 = 8'h00;
  logic [7:0] cw = 8'h00, cs = 8'h00, cb = 8'h00, cf = 8'h00, cp = 8'h00;
  logic [7:0] reg_rdata, rw, rs, rb;
  logic [1:0] q_phase;
  logic [14:0] cpu_pc, vec_addr;
  logic load_vec, wake_core, restore_ctx, rd_pend = 1'b0;
  logic [7:0] exp_q[$]; // expected read data, oldest first
  int n_mismatch = 0, n_checks = 0, n_vec = 0, n, seed;
  // 50 MHz reference clock, one q phase per cycle
  always #10 ref_clk = ~ref_clk;
  cic_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin),
    .timer0_overflow(t0_ovf), .per_pin_change_flags(chg), .periph_set_1(ps1),
    .periph_set_2(ps2), .q_phase(q_phase), .cpu_sleeping(cpu_sleeping), .cpu_pc(cpu_pc),
    .ret_from_irq(ret_from_irq), .cur_w(cw), .cur_status(cs), .cur_bank_select(cb),
    .cur_file_select(cf), .cur_pc_high_latch(cp), .flush_prefetch(), .push_pc(),
    .push_addr(), .load_vector(load_vec), .vector_addr(vec_addr), .wake_core(wake_core),
    .restore_ctx(restore_ctx), .rst_w(rw), .rst_status(rs), .rst_bank_select(rb),
    .rst_file_select(), .rst_pc_high_latch());
  cic_core_model core_u (.ref_clk(ref_clk), .rstn(rstn), .load_vector(load_vec),
    .vector_addr(vec_addr), .q_phase(q_phase), .cpu_pc(cpu_pc));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one-cycle write, then a quiet cycle so strobes never double up
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // read strobe; the monitor compares the data one cycle later
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // bounded wait on vector (0), restore (1) or wake (2)
  task automatic wait_on(input int which, input int lim, output int k);
    logic hit;
    k = 0;
    hit = 1'b0;
    // values sampled at the edge are those that stood in the cycle before
    do
    begin
      @(posedge ref_clk);
      k++;
      case (which)
        0: hit = load_vec;
        1: hit = restore_ctx;
        default: hit = wake_core;
      endcase
    end
    while (hit !== 1'b1 && k < lim);
  endtask
  task automatic pulse(input logic [7:0] d);
    ps1 <= d;
    ps2 <= d;
    @(posedge ref_clk);
    ps1 <= 8'h00;
    ps2 <= 8'h00;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // monitor: read data and vector entries
  always @(posedge ref_clk)
  begin
    rd_pend <= reg_rd;
    if (rd_pend && exp_q.size() > 0)
      check(16'(reg_rdata), 16'(exp_q.pop_front()));
    if (load_vec === 1'b1)
    begin
      n_vec <= n_vec + 1;
      check(16'(vec_addr), 16'(cic_pkg::VECTOR_ADDR));
    end
  end
  // watchdog well past the planned run
  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    seed = $urandom(32'h971e);
    idle(10);
    rstn <= 1'b1;
    idle(1);
    // reset state and a refused address
    rd(cic_pkg::REG_INTCTL, 8'h00);
    rd(cic_pkg::REG_PEN1, 8'h00);
    rd(4'hF, 8'h00);
    // every source sets its flag with all enables clear
    v = 8'h01 << ($urandom % 8);
    pulse(v);
    t0_ovf <= 1'b1;
    ext_irq_pin <= 1'b0;
    chg <= v;
    idle(6);
    rd(cic_pkg::REG_PFLAG1, v);
    rd(cic_pkg::REG_PFLAG2, v);
    rd(cic_pkg::REG_INTCTL, 8'h07);
    wr(cic_pkg::REG_INTCTL, 8'h00);
    rd(cic_pkg::REG_INTCTL, 8'h01);
    chg <= 8'h00;
    t0_ovf <= 1'b0;
    idle(3);
    rd(cic_pkg::REG_INTCTL, 8'h00);
    // wrong edge ignored, then rising selected
    ext_irq_pin <= 1'b1;
    idle(6);
    rd(cic_pkg::REG_INTCTL, 8'h00);
    wr(cic_pkg::REG_OPTS, 8'h01);
    ext_irq_pin <= 1'b0;
    idle(6);
    rd(cic_pkg::REG_INTCTL, 8'h00);
    ext_irq_pin <= 1'b1;
    idle(6);
    rd(cic_pkg::REG_INTCTL, 8'h02);
    // pending without group or pin enable must not vector
    wr(cic_pkg::REG_PEN1, v);
    wr(cic_pkg::REG_INTCTL, 8'h82);
    idle(40);
    check(16'(n_vec), 16'h0);
    // firmware clears flags before enabling, then a timed event
    wr(cic_pkg::REG_PFLAG1, 8'h00);
    cw <= $urandom;
    cs <= $urandom;
    cb <= $urandom;
    cf <= $urandom;
    cp <= $urandom;
    wr(cic_pkg::REG_INTCTL, 8'hC0);
    pulse(v);
    wait_on(0, 40, n);
    check(16'(n <= 16), 16'h1);
    idle(2);
    rd(cic_pkg::REG_INTCTL, 8'h40);
    rd(cic_pkg::REG_SH_W, cw);
    rd(cic_pkg::REG_SH_BSR, cb);
    rd(cic_pkg::REG_SH_FSR, cf);
    rd(cic_pkg::REG_SH_PCL, cp);
    // service edits a shadow and the live context, then returns
    nw = $urandom;
    wr(cic_pkg::REG_SH_W, nw);
    wr(cic_pkg::REG_PFLAG1, 8'h00);
    s0 = cs;
    cs <= ~cs;
    cw <= ~cw;
    cb <= ~cb;
    ret_from_irq <= 1'b1;
    idle(1);
    ret_from_irq <= 1'b0;
    wait_on(1, 20, n);
    check(16'(n < 20), 16'h1);
    check(16'(rw), 16'(nw));
    check(16'(rb), 16'(cb ^ 8'hFF));
    check(16'(rs), 16'(s0 ^ 8'h18));
    idle(2);
    rd(cic_pkg::REG_INTCTL, 8'hC0);
    idle(40);
    check(16'(n_vec), 16'h1);
    // wake from sleep, vector only once awake again
    cpu_sleeping <= 1'b1;
    idle(4);
    pulse(v);
    wait_on(2, 40, n);
    check(16'(n < 40), 16'h1);
    idle(8);
    check(16'(n_vec), 16'h1);
    cpu_sleeping <= 1'b0;
    wait_on(0, 40, n);
    check(16'(n < 40), 16'h1);
    // second reset mid-run
    idle(2);
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(1);
    rd(cic_pkg::REG_INTCTL, 8'h00);
    rd(cic_pkg::REG_PEN1, 8'h00);
    idle(2);
    end_of_test();
  end
endmodule
`default_nettype wire
